// ### bench/cld_detect_checker.sv
// Timing and consistency checks of the cold load detector outputs.
// Assumes binding to cld_detect; one clock domain, async low reset.
`timescale 1ns/100ps
module cld_detect_checker #(
   parameter MW          = 16,
   parameter CW          = 16,
   parameter TICK_CYCLES = 4
) (
   input wire          i_clock,                         // System clock
   input wire          i_rstn,                          // Reset, active low
   input wire [MW-1:0] i_phase_a_fundamental,           // Phase a
   input wire [MW-1:0] i_phase_b_fundamental,           // Phase b
   input wire [MW-1:0] i_phase_c_fundamental,           // Phase c
   input wire [MW-1:0] i_overcurrent_release_threshold, // Overcurrent setting
   input wire          i_counter_clear,                 // Counter clear
   input wire          o_cycle_start,                   // Processing pulse
   input wire          o_cold_load_active,              // Active output
   input wire          o_blocked,                       // Blocked output
   input wire [2:0]    o_detector_state,                // State report
   input wire [5:0]    o_event_on,                      // Rising events
   input wire [5:0]    o_event_off,                     // Falling events
   input wire [CW-1:0] o_activation_count,              // Activations
   input wire [CW-1:0] o_blocked_count                  // Blocked events
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rstn);
   integer gap;
   reg     seen;
   // Clocks since the last pulse; the first period after reset is exempt
   always @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         gap  <= 0;
         seen <= 1'b0;
      end else if (o_cycle_start) begin
         gap  <= 0;
         seen <= 1'b1;
      end else begin
         gap <= gap + 1;
      end
   end
   sequence act_pulse_s;
      o_event_on[4] ##1 !o_event_on[4];
   endsequence
   sequence rel_pulse_s;
      o_event_off[4] ##1 !o_event_off[4];
   endsequence
   tick_period_a: assert property (o_cycle_start && seen |-> gap == TICK_CYCLES - 1)
      else $error("processing pulse spacing wrong");
   out_timing_a: assert property (!$past(o_cycle_start, 2) |-> $stable(o_detector_state) &&
      $stable(o_cold_load_active) && $stable(o_blocked)) else $error("output moved outside a step");
   act_event_a: assert property ($rose(o_cold_load_active) |-> act_pulse_s)
      else $error("activation event pulse missing");
   rel_event_a: assert property ($fell(o_cold_load_active) |-> rel_pulse_s)
      else $error("release event pulse missing");
   act_excl_a: assert property (!(o_cold_load_active && o_blocked))
      else $error("active and blocked together");
   state_map_a: assert property (o_cold_load_active || o_blocked |->
      o_detector_state == (o_blocked ? 3'h4 : 3'h3)) else $error("state report disagrees");
   state_range_a: assert property (o_detector_state <= 3'h4)
      else $error("state code out of range");
   over_release_a: assert property (o_cycle_start && o_cold_load_active &&
      (i_phase_a_fundamental > i_overcurrent_release_threshold ||
       i_phase_b_fundamental > i_overcurrent_release_threshold ||
       i_phase_c_fundamental > i_overcurrent_release_threshold) |-> ##2 !o_cold_load_active)
      else $error("overcurrent did not release");
   act_count_a: assert property ($rose(o_cold_load_active) |-> o_activation_count ==
      ($past(i_counter_clear) ? 1 : $past(o_activation_count) + 1'b1)) else $error("activation count wrong");
   blk_count_a: assert property ($rose(o_blocked) |-> o_blocked_count ==
      ($past(i_counter_clear) ? 1 : $past(o_blocked_count) + 1'b1)) else $error("blocked count wrong");
   count_clear_a: assert property (i_counter_clear && !$past(o_cycle_start) |=>
      o_activation_count == 0 && o_blocked_count == 0) else $error("counters not cleared");
endmodule
bind cld_detect cld_detect_checker #(.MW(MW), .CW(CW), .TICK_CYCLES(TICK_CYCLES)) chk (
   .i_clock(i_clock), .i_rstn(i_rstn), .i_phase_a_fundamental(i_phase_a_fundamental),
   .i_phase_b_fundamental(i_phase_b_fundamental), .i_phase_c_fundamental(i_phase_c_fundamental),
   .i_overcurrent_release_threshold(i_overcurrent_release_threshold), .i_counter_clear(i_counter_clear),
   .o_cycle_start(o_cycle_start), .o_cold_load_active(o_cold_load_active), .o_blocked(o_blocked),
   .o_detector_state(o_detector_state), .o_event_on(o_event_on), .o_event_off(o_event_off),
   .o_activation_count(o_activation_count), .o_blocked_count(o_blocked_count));

// ### bench/cld_detect_test.sv
// Self-checking bench of cld_detect against a step-level model.
// Assumes a short processing cycle; the source model feeds currents and block.
`timescale 1ns/100ps
`include "cld_regs.vh"
module cld_detect_test;
   localparam TICK = 4;
   reg          i_clock = 1'b0;
   reg          i_rstn  = 1'b0;
   reg  [15:0]  pa = 16'h0032, pb = 16'h0032, pc = 16'h0032;
   reg          pk = 1'b0;
   reg  [15:0]  w_lo = `CLD_LOW_DEFAULT, w_hi = `CLD_HIGH_DEFAULT, w_ov = `CLD_OVER_DEFAULT;
   reg  [18:0]  w_set = 19'h0_0003, w_max = 19'h0_0004, w_min = 19'h0_0002;
   reg          w_clr = 1'b0;
   wire [105:0] cfg = {w_clr, w_min, w_max, w_set, w_ov, w_hi, w_lo};
   reg  [105:0] cfg_q = {106{1'b0}};
   wire [15:0]  ph_a, ph_b, ph_c, acnt, bcnt;
   wire [5:0]   ev_on, ev_off;
   wire [2:0]   dstate;
   wire         blk, cyc, act, blkd;
   reg  [31:0]  seed = 32'h0000_0014;
   reg  [2:0]   lo = 3'h0, hi = 3'h0, ov = 3'h0;
   reg  [5:0]   ep = 6'h04, lv = 6'h00;
   integer      mismatches = 0, samples_checked = 0;
   integer      st = 0, tc = 0, mc = 0, xc = 0, ma = 0, mb = 0;
   always #25 i_clock = ~i_clock;
   // Settings reach the design on a rising edge, never mid-cycle
   always @(posedge i_clock) cfg_q <= cfg;
   cld_source_model src (.i_clock(i_clock), .i_req_a(pa), .i_req_b(pb), .i_req_c(pc), .i_req_block(pk),
      .o_phase_a(ph_a), .o_phase_b(ph_b), .o_phase_c(ph_c), .o_block(blk));
   cld_detect #(.TICK_CYCLES(TICK)) uut (.i_clock(i_clock), .i_rstn(i_rstn),
      .i_phase_a_fundamental(ph_a), .i_phase_b_fundamental(ph_b), .i_phase_c_fundamental(ph_c),
      .i_low_current_threshold(cfg_q[15:0]), .i_high_current_threshold(cfg_q[31:16]),
      .i_overcurrent_release_threshold(cfg_q[47:32]), .i_start_delay_time(cfg_q[66:48]),
      .i_max_inrush_time(cfg_q[85:67]), .i_min_hold_time(cfg_q[104:86]), .i_block(blk),
      .i_counter_clear(cfg_q[105]), .o_cycle_start(cyc), .o_cold_load_active(act), .o_blocked(blkd),
      .o_detector_state(dstate), .o_event_on(ev_on), .o_event_off(ev_off),
      .o_activation_count(acnt), .o_blocked_count(bcnt));
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   // Comparator flag with the fixed 97 percent drop-out
   function upd(input f, input integer m, input integer t, input integer under);
      begin
         if (under) upd = f ? (m * 97 <= t * 100) : (m < t);
         else upd = f ? (m * 100 >= t * 97) : (m > t);
      end
   endfunction
   task model(input integer a, input integer b, input integer c, input integer bk);
      integer i, rel;
      integer m [0:2];
      begin
         m[0] = a;
         m[1] = b;
         m[2] = c;
         rel = 0;
         for (i = 0; i < 3; i = i + 1) begin
            lo[i] = upd(lo[i], m[i], w_lo, 1);
            hi[i] = upd(hi[i], m[i], w_hi, 0);
            ov[i] = upd(ov[i], m[i], w_ov, 0);
         end
         if (st == 5) begin
            if (!(&lo)) st = 0;
         end else if (st < 2) begin
            tc = (&lo) ? tc + 1 : 0;
            if ((&lo) && tc >= w_set) begin
               tc = 0;
               mc = 0;
               if (bk) mb = mb + 1;
               else ma = ma + 1;
               st = bk ? 5 : 2;
            end
         end else begin
            mc = mc + 1;
            xc = xc + 1;
            if ((|ov) || bk) rel = 1;
            else if ((&hi) && st == 2) begin
               st = 3;
               xc = 0;
            end else if (&hi) begin
               st = 3;
               rel = xc >= w_max;
            end else begin
               if (st == 3) st = 4;
               rel = mc >= w_min;
            end
         end
         if (rel) st = 0;
      end
   endtask
   task chk_flag(input got, input integer exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp[0]) begin
            mismatches = mismatches + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp[0]);
         end
      end
   endtask
   task chk_word(input [15:0] got, input integer exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp[15:0]) begin
            mismatches = mismatches + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp[15:0]);
         end
      end
   endtask
   // One processing cycle: request, wait for the sampling edge, compare
   task step(input integer a, input integer b, input integer c, input integer bk, input integer cl);
      integer n;
      begin
         pa = a;
         pb = b;
         pc = c;
         pk = bk;
         w_clr = cl;
         @(posedge i_clock);
         #1 w_clr = 1'b0;
         n = 0;
         while (cyc !== 1'b1 && n < 9) begin
            @(posedge i_clock);
            #1 n = n + 1;
         end
         @(posedge i_clock);
         @(posedge i_clock);
         #1;
         if (cl) begin
            ma = 0;
            mb = 0;
         end
         model(a, b, c, bk);
         chk_flag(act, st >= 2 && st <= 4);
         chk_flag(blkd, st == 5);
         chk_word(dstate, st == 5 ? 4 : st >= 2 ? 3 : (|ov) ? 2 : (&lo) ? 1 : 0);
         chk_word(acnt, ma);
         chk_word(bcnt, mb);
         // Event levels: block, active, overcurrent, load normal, high, low
         lv = {bk != 0, st >= 2 && st <= 4, |ov, !(&lo) && !(&hi), &hi, &lo};
         chk_word(ev_on, lv & ~ep);
         chk_word(ev_off, ~lv & ep);
         ep = lv;
      end
   endtask
   task run(input integer n, input integer m, input integer bk);
      repeat (n) step(m, m, m, bk, 0);
   endtask
   // Random currents well inside the band between low and high settings
   task between(input integer n);
      integer k;
      integer v [0:2];
      begin
         repeat (n) begin
            for (k = 0; k < 3; k = k + 1) begin
               seed = xs(seed);
               v[k] = 30 + seed % 80;
            end
            step(v[0], v[1], v[2], 0, 0);
         end
      end
   endtask
   task test_done;
      begin
         $display("checks %0d mismatches %0d", samples_checked, mismatches);
         if (mismatches == 0 && samples_checked > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   initial begin
      #(50 * TICK * 400);
      mismatches = mismatches + 1;
      test_done;
   end
   initial begin
      repeat (6) @(posedge i_clock);
      i_rstn <= 1'b1;
      // Partial low, short dip, then no pick-up with two phases exactly at the setting
      step(19, 19, 50, 0, 0);
      run(2, 19, 0);
      between(1);
      step(19, 20, 20, 0, 0);
      run(2, 20, 0);
      between(3);
      $display("test 1 done");
      // Inrush kept by hysteresis until the maximum time runs out
      w_min = 19'h0_0008;
      run(3, 19, 0);
      step(130, 130, 110, 0, 0);
      run(1, 130, 0);
      run(4, 117, 0);
      between(2);
      $display("test 2 done");
      // Short inrush, then minimum time prolongs the output
      w_min = 19'h0_0006;
      w_max = 19'h0_0014;
      run(3, 19, 0);
      run(2, 130, 0);
      between(5);
      $display("test 3 done");
      // Overcurrent on one phase releases at once
      run(3, 19, 0);
      run(1, 130, 0);
      step(130, 210, 130, 0, 0);
      between(2);
      $display("test 4 done");
      // Zero start time, block while active, blocked pick-up, clear
      w_set = 19'h0_0000;
      w_min = 19'h0_0008;
      run(1, 19, 0);
      run(3, 19, 1);
      step(60, 60, 60, 1, 1);
      w_set = 19'h0_0002;
      run(3, 19, 1);
      between(2);
      $display("test 5 done");
      test_done;
   end
endmodule

// ### bench/cld_source_model.sv
// Far side model: phase measurement chain and blocking matrix.
// Assumes the bench requests new values between processing cycles.
`timescale 1ns/100ps
module cld_source_model (
   input  wire        i_clock,             // System clock
   input  wire [15:0] i_req_a,             // Requested phase a
   input  wire [15:0] i_req_b,             // Requested phase b
   input  wire [15:0] i_req_c,             // Requested phase c
   input  wire        i_req_block,         // Requested block level
   output reg  [15:0] o_phase_a = 16'h0000, // Fundamental, phase a
   output reg  [15:0] o_phase_b = 16'h0000, // Fundamental, phase b
   output reg  [15:0] o_phase_c = 16'h0000, // Fundamental, phase c
   output reg         o_block   = 1'b0      // Blocking matrix output
);
   // One clock of filter latency; block leads the sampling edge by a clock
   always @(posedge i_clock) begin
      o_phase_a <= i_req_a;
      o_phase_b <= i_req_b;
      o_phase_c <= i_req_c;
      o_block   <= i_req_block;
   end
endmodule

// ### inc/cld_regs.vh
// Named constants of the cold load pick-up detector.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef CLD_DETECT_REGS_VH
`define CLD_DETECT_REGS_VH

// Clock rate and processing cycle length
`define CLD_CLOCK_KHZ      32'h0000_4E20
`define CLD_TICK_MS        32'h0000_0005

// Hysteresis ratio against the full setting, in percent
`define CLD_RESET_PCT      8'h61
`define CLD_FULL_PCT       8'h64

// Threshold defaults in 0.01 x In steps
`define CLD_LOW_DEFAULT    16'h0014
`define CLD_HIGH_DEFAULT   16'h0078
`define CLD_OVER_DEFAULT   16'h00C8

// Timer defaults in processing cycles of 5 ms
`define CLD_TSTART_DEFAULT 19'h0_07D0
`define CLD_MAX_INRUSH_TIME_DEFAULT   19'h0_1770
`define CLD_MIN_HOLD_TIME_DEFAULT   19'h0_0008

// Internal sequencer states
`define CLD_S_IDLE         3'h0
`define CLD_S_LOWWAIT      3'h1
`define CLD_S_HOLD         3'h2
`define CLD_S_INRUSH       3'h3
`define CLD_S_POST         3'h4
`define CLD_S_BLOCKED      3'h5

// Reported detector state codes
`define CLD_R_NORMAL       3'h0
`define CLD_R_LOWCURR      3'h1
`define CLD_R_OVERCURR     3'h2
`define CLD_R_ACTIVE       3'h3
`define CLD_R_BLOCKED      3'h4

// Event vector bit positions
`define CLD_EV_LOW         0
`define CLD_EV_HIGH        1
`define CLD_EV_NORMAL      2
`define CLD_EV_OVER        3
`define CLD_EV_ACT         4
`define CLD_EV_BLOCK       5
// Previous levels after reset: load normal already on, so no false pulse
`define CLD_EV_RESET       6'h04

`endif

// ### verilog/cld_compare.v
// Three-phase threshold comparator with built-in hysteresis.
// Assumes magnitudes and setting share one unit; updates on i_step only.
`timescale 1ns/100ps
`include "cld_regs.vh"
module cld_compare #(
   parameter W     = 16,
   parameter UNDER = 0
) (
   input  wire           i_clock,     // System clock
   input  wire           i_rstn,      // Async reset, active low
   input  wire           i_step,      // Processing cycle pulse
   input  wire [3*W-1:0] i_mags,      // Phase magnitudes, a in low bits
   input  wire [W-1:0]   i_threshold, // Shared setting
   output wire [2:0]     o_flags      // Per-phase picked-up flags
);
   genvar p;
   generate
      for (p = 0; p < 3; p = p + 1) begin : g_phase
         wire [W-1:0] mag = i_mags[p*W +: W];
         wire [W+7:0] mag_full  = {8'h00, mag} * `CLD_FULL_PCT;
         wire [W+7:0] mag_reset = {8'h00, mag} * `CLD_RESET_PCT;
         wire [W+7:0] thr_full  = {8'h00, i_threshold} * `CLD_FULL_PCT;
         wire [W+7:0] thr_reset = {8'h00, i_threshold} * `CLD_RESET_PCT;
         // Under mode drops out above setting/0.97, over mode below 0.97*setting
         wire pick = (UNDER != 0) ? (mag < i_threshold) : (mag > i_threshold);
         wire drop = (UNDER != 0) ? (mag_reset > thr_full) : (mag_full < thr_reset);
         reg  flag;
         // Hysteresis keeps flags from chattering near the setting
         always @(posedge i_clock or negedge i_rstn) begin
            if (!i_rstn) begin
               flag <= 1'b0;
            end else if (i_step) begin
               if (!flag) begin
                  flag <= pick;
               end else if (drop) begin
                  flag <= 1'b0;
               end
            end
         end
         assign o_flags[p] = flag;
      end
   endgenerate
endmodule

// ### verilog/cld_detect.v
// Cold load pick-up detector: comparators, timers, state report, events.
// Assumes synchronous inputs, settings held by the setting group logic,
// and magnitudes already reduced to fundamental components.
//
// Notes on behaviour
// - Inputs are fundamental component per phase
// - Comparisons drop out at 97 percent hysteresis
// - One setting shared by all three phases
// - Low condition needs all phases below
// - High condition needs all phases above
// - Any phase overcurrent releases output immediately
// - Setting changes apply live without restart
// - Block input sampled once per cycle
// - Unblocked pick-up asserts active, starts timing
// - Blocked pick-up flags blocked, nothing more
// - Block while active releases like reset
// - Active only after low lasts start time
// - Short dip ignored, start timer restarts
// - Zero start time activates same cycle
// - Persistent inrush released at maximum time
// - Start-up over between thresholds clears output once minimum time has run
// - Minimum hold time, also the reclaim time
// - No inrush: release after minimum time
// - Inrush during hold starts maximum timer
// - State reported as one of five
// - Cumulative counters and on/off event pulses
`timescale 1ns/100ps
`include "cld_regs.vh"
module cld_detect #(
   parameter MW          = 16,
   parameter TW          = 19,
   parameter CW          = 16,
   parameter TICK_CYCLES = `CLD_TICK_MS * `CLD_CLOCK_KHZ
) (
   input  wire          i_clock,                          // 20 MHz system clock
   input  wire          i_rstn,                           // Async reset, active low
   input  wire [MW-1:0] i_phase_a_fundamental,            // Phase a, 0.01 x In
   input  wire [MW-1:0] i_phase_b_fundamental,            // Phase b, 0.01 x In
   input  wire [MW-1:0] i_phase_c_fundamental,            // Phase c, 0.01 x In
   input  wire [MW-1:0] i_low_current_threshold,          // Low setting
   input  wire [MW-1:0] i_high_current_threshold,         // High setting
   input  wire [MW-1:0] i_overcurrent_release_threshold,  // Overcurrent setting
   input  wire [TW-1:0] i_start_delay_time,               // Start time, cycles
   input  wire [TW-1:0] i_max_inrush_time,                // Max time, cycles
   input  wire [TW-1:0] i_min_hold_time,                  // Min time, cycles
   input  wire          i_block,                          // Blocking matrix input
   input  wire          i_counter_clear,                  // Clears both counters
   output reg           o_cycle_start,                    // Processing cycle pulse
   output reg           o_cold_load_active,               // Cold load active
   output reg           o_blocked,                        // Blocked indication
   output reg  [2:0]    o_detector_state,                 // Five-value state report
   output reg  [5:0]    o_event_on,                       // Rising event pulses
   output reg  [5:0]    o_event_off,                      // Falling event pulses
   output reg  [CW-1:0] o_activation_count,               // Activation events
   output reg  [CW-1:0] o_blocked_count                   // Blocked events
);

   // Timer helpers
   function timer_done;
      input [TW-1:0] cnt;
      input [TW-1:0] set;
      begin
         timer_done = (cnt >= set);
      end
   endfunction

   function [TW-1:0] sat_inc;
      input [TW-1:0] cnt;
      begin
         sat_inc = (&cnt) ? cnt : cnt + {{(TW-1){1'b0}}, 1'b1};
      end
   endfunction

   // Processing cycle divider; one-cycle enable, no second clock
   reg [31:0] div_cnt;
   always @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         div_cnt       <= 32'h0000_0000;
         o_cycle_start <= 1'b0;
      end else if (div_cnt >= TICK_CYCLES - 1) begin
         div_cnt       <= 32'h0000_0000;
         o_cycle_start <= 1'b1;
      end else begin
         div_cnt       <= div_cnt + 32'h0000_0001;
         o_cycle_start <= 1'b0;
      end
   end

   // Block sampled at the cycle start, held for the whole cycle
   reg block_s;
   reg eval;
   always @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         block_s <= 1'b0;
         eval    <= 1'b0;
      end else begin
         eval <= o_cycle_start;
         if (o_cycle_start) begin
            block_s <= i_block;
         end
      end
   end

   // Phase magnitudes packed for the comparators
   wire [3*MW-1:0] mags = {i_phase_c_fundamental, i_phase_b_fundamental, i_phase_a_fundamental};
   wire [2:0]      low_flags;
   wire [2:0]      high_flags;
   wire [2:0]      over_flags;

   // Settings are read live each cycle, so group changes apply at once
   cld_compare #(.W(MW), .UNDER(1)) u_low (
      .i_clock     (i_clock),
      .i_rstn      (i_rstn),
      .i_step      (o_cycle_start),
      .i_mags      (mags),
      .i_threshold (i_low_current_threshold),
      .o_flags     (low_flags)
   );
   cld_compare #(.W(MW), .UNDER(0)) u_high (
      .i_clock     (i_clock),
      .i_rstn      (i_rstn),
      .i_step      (o_cycle_start),
      .i_mags      (mags),
      .i_threshold (i_high_current_threshold),
      .o_flags     (high_flags)
   );
   cld_compare #(.W(MW), .UNDER(0)) u_over (
      .i_clock     (i_clock),
      .i_rstn      (i_rstn),
      .i_step      (o_cycle_start),
      .i_mags      (mags),
      .i_threshold (i_overcurrent_release_threshold),
      .o_flags     (over_flags)
   );

   // Combined current conditions
   wire low_all  = &low_flags;
   wire high_all = &high_flags;
   wire over_any = |over_flags;
   wire between  = !low_all && !high_all;

   // Sequencer and timers
   reg [2:0]    state;
   reg [TW-1:0] start_cnt;
   reg [TW-1:0] min_cnt;
   reg [TW-1:0] max_cnt;
   reg [2:0]    next_state;
   reg [TW-1:0] next_start_cnt;
   reg [TW-1:0] next_min_cnt;
   reg [TW-1:0] next_max_cnt;
   reg          act_evt;
   reg          blk_evt;

   wire [TW-1:0] start_inc = sat_inc(start_cnt);
   wire [TW-1:0] min_inc   = sat_inc(min_cnt);
   wire [TW-1:0] max_inc   = sat_inc(max_cnt);

   // Next-state logic; evaluated one clock after the cycle start
   always @* begin
      next_state     = state;
      next_start_cnt = start_cnt;
      next_min_cnt   = min_cnt;
      next_max_cnt   = max_cnt;
      act_evt        = 1'b0;
      blk_evt        = 1'b0;
      case (state)
         `CLD_S_IDLE, `CLD_S_LOWWAIT: begin
            if (low_all) begin
               next_start_cnt = start_inc;
               if (timer_done(start_inc, i_start_delay_time)) begin
                  next_start_cnt = {TW{1'b0}};
                  next_min_cnt   = {TW{1'b0}};
                  next_max_cnt   = {TW{1'b0}};
                  if (block_s) begin
                     next_state = `CLD_S_BLOCKED;
                     blk_evt    = 1'b1;
                  end else begin
                     next_state = `CLD_S_HOLD;
                     act_evt    = 1'b1;
                  end
               end else begin
                  next_state = `CLD_S_LOWWAIT;
               end
            end else begin
               next_start_cnt = {TW{1'b0}};
               next_state     = `CLD_S_IDLE;
            end
         end
         `CLD_S_BLOCKED: begin
            // No further processing until the low condition itself ends
            if (!low_all) begin
               next_state = `CLD_S_IDLE;
            end
         end
         `CLD_S_HOLD: begin
            next_min_cnt = min_inc;
            if (over_any || block_s) begin
               next_state = `CLD_S_IDLE;
            end else if (high_all) begin
               next_max_cnt = {TW{1'b0}};
               next_state   = `CLD_S_INRUSH;
            end else if (timer_done(min_inc, i_min_hold_time)) begin
               next_state = `CLD_S_IDLE;
            end
         end
         `CLD_S_INRUSH: begin
            next_min_cnt = min_inc;
            next_max_cnt = max_inc;
            if (over_any || block_s) begin
               next_state = `CLD_S_IDLE;
            end else if (high_all && timer_done(max_inc, i_max_inrush_time)) begin
               next_state = `CLD_S_IDLE;
            end else if (between) begin
               if (timer_done(min_inc, i_min_hold_time)) begin
                  next_state = `CLD_S_IDLE;
               end else begin
                  next_state = `CLD_S_POST;
               end
            end
         end
         `CLD_S_POST: begin
            next_min_cnt = min_inc;
            if (over_any || block_s) begin
               next_state = `CLD_S_IDLE;
            end else if (high_all) begin
               next_state = `CLD_S_INRUSH;
            end else if (timer_done(min_inc, i_min_hold_time)) begin
               next_state = `CLD_S_IDLE;
            end
         end
         default: begin
            next_state = `CLD_S_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         state     <= `CLD_S_IDLE;
         start_cnt <= {TW{1'b0}};
         min_cnt   <= {TW{1'b0}};
         max_cnt   <= {TW{1'b0}};
      end else if (eval) begin
         state     <= next_state;
         start_cnt <= next_start_cnt;
         min_cnt   <= next_min_cnt;
         max_cnt   <= next_max_cnt;
      end
   end

   // Output levels follow the next state so release is immediate
   wire next_active = (next_state == `CLD_S_HOLD) || (next_state == `CLD_S_INRUSH) ||
                      (next_state == `CLD_S_POST);
   wire next_blocked = (next_state == `CLD_S_BLOCKED);

   // Five-value report; overcurrent shown only when not active or blocked
   reg [2:0] next_report;
   always @* begin
      next_report = `CLD_R_NORMAL;
      if (next_blocked) begin
         next_report = `CLD_R_BLOCKED;
      end else if (next_active) begin
         next_report = `CLD_R_ACTIVE;
      end else if (over_any) begin
         next_report = `CLD_R_OVERCURR;
      end else if (low_all) begin
         next_report = `CLD_R_LOWCURR;
      end
   end

   // Event level vector and its previous value
   wire [5:0] ev_level = {block_s, next_active, over_any, between, high_all, low_all};
   reg  [5:0] ev_prev;

   always @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_cold_load_active <= 1'b0;
         o_blocked          <= 1'b0;
         o_detector_state   <= `CLD_R_NORMAL;
         o_event_on         <= 6'h00;
         o_event_off        <= 6'h00;
         ev_prev            <= `CLD_EV_RESET;
      end else if (eval) begin
         o_cold_load_active <= next_active;
         o_blocked          <= next_blocked;
         o_detector_state   <= next_report;
         o_event_on         <= ev_level & ~ev_prev;
         o_event_off        <= ~ev_level & ev_prev;
         ev_prev            <= ev_level;
      end else begin
         o_event_on  <= 6'h00;
         o_event_off <= 6'h00;
      end
   end

   // Counters; an event in the clear cycle still counts
   always @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_activation_count <= {CW{1'b0}};
         o_blocked_count    <= {CW{1'b0}};
      end else begin
         if (eval && act_evt) begin
            o_activation_count <= i_counter_clear ? {{(CW-1){1'b0}}, 1'b1} :
                                  o_activation_count + {{(CW-1){1'b0}}, 1'b1};
         end else if (i_counter_clear) begin
            o_activation_count <= {CW{1'b0}};
         end
         if (eval && blk_evt) begin
            o_blocked_count <= i_counter_clear ? {{(CW-1){1'b0}}, 1'b1} :
                               o_blocked_count + {{(CW-1){1'b0}}, 1'b1};
         end else if (i_counter_clear) begin
            o_blocked_count <= {CW{1'b0}};
         end
      end
   end

endmodule
